// *** core/ctwf_top.sv ***
// mode, flag selection and wakeup logic of a standalone can transceiver
// Operation
// - normal: fault shows bus failure after four edges
// - normal: wake source shown before fourth edge
// - listen from quiet modes shows power-on flag
// - listen from normal shows local failure flag
// - sleep after hold time or undervoltage
// - regulator output floats only in sleep
// - either wake pin edge is local wake
// - wakeup sets flag, shown on rxd and fault
// - bus wake: dominant, recessive, dominant within window
// - bias follows a persisting opposite wake level
// - wake pulse passes filter timer before release
// - sleep exits on standby rise with logic supply
// - wakeup beats a simultaneous go-to-sleep
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module ctwf_top #(
  parameter int WIN_CYC = ctwf_pkg::BWWIN_CYC,
  parameter int HOLD_C = ctwf_pkg::HOLD_CYC,
  parameter int WAKE_C = ctwf_pkg::WAKE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ctwf_pkg::ctwf_pins_t pins_i,
  output logic fault_flag_out_n,
  output logic rxd_out,
  output logic regulator_control_out,
  output logic regulator_control_oe,
  output logic wake_bias_high,
  output logic irq_o
);
  import ctwf_pkg::*;

  // ==========================================================
  // pin synchronisers
  ctwf_pins_t meta_reg;  // first stage, read by pins_s only
  ctwf_pins_t pins_s;    // safe copy for all logic
  // every pin crosses in from outside the clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= PINS_RST;
      pins_s <= PINS_RST;
    end else begin
      meta_reg <= pins_i;
      pins_s <= meta_reg;
    end
  end

  // ==========================================================
  // mode decode
  // pin pair to selected mode; sleep is never selected directly
  function automatic ctwf_mode_t pin_mode(input logic stb_n,
                                          input logic en);
    pin_mode = stb_n ? (en ? M_NORMAL : M_LISTEN)
                     : (en ? M_GTS : M_STANDBY);
  endfunction : pin_mode

  ctwf_mode_t mode_reg, mode_next;   // operating mode
  logic stb_prev_reg;                // last standby select level
  logic [1:0] ctrl_reg;              // wake source enables
  logic [IRQ_W-1:0] ist_reg;         // sticky events
  logic [IRQ_W-1:0] imsk_reg;        // event mask
  logic wake_flag_reg;               // wakeup flag
  logic power_on_flag_reg;                    // power_on_flag
  logic src_local_reg;               // wake source was local
  logic from_norm_reg;               // listen entered from normal
  logic [CNT_W-1:0] hold_reg;        // go-to-sleep hold counter
  logic [CNT_W-1:0] dom_reg;         // txd dominant length
  logic txd_prev_reg;
  logic [2:0] edge_reg;              // qualified txd edges
  logic fault_n_reg, fault_n_next;
  logic rxd_reg, rxd_next;
  logic inh_reg;
  logic ack_reg;
  logic [31:0] dat_reg;

  wire ctwf_mode_t sel_mode = pin_mode(pins_s.standby_select_n,
                                       pins_s.enable_select);
  wire supplies_ok = pins_s.logic_supply & pins_s.xcvr_supply;
  wire uv = !supplies_ok;
  wire stb_rise = pins_s.standby_select_n & !stb_prev_reg;
  // wake events are heard only in the quiet modes
  wire quiet = (mode_reg == M_SLEEP) | (mode_reg == M_STANDBY) |
               (mode_reg == M_GTS);

  // ==========================================================
  // wake sources
  logic bw_pulse;
  logic lw_pulse;
  ctwf_bus_wake #(
    .PH_CYC(BWPH_CYC),
    .WIN_CYC(WIN_CYC)
  ) u_bus_wake (
    .clk(clk),
    .resetn(resetn),
    .enable(quiet & ctrl_reg[CTRL_BUSW]),
    .bus_dom(pins_s.bus_dom),
    .wake_pulse(bw_pulse)
  );
  // the filter tracks bias in every mode so no stale edge is kept
  ctwf_wake_filter #(
    .CYC(WAKE_C)
  ) u_wake_filter (
    .clk(clk),
    .resetn(resetn),
    .level(pins_s.wake),
    .bias_high(wake_bias_high),
    .event_pulse(lw_pulse)
  );
  wire lw_ev = lw_pulse & ctrl_reg[CTRL_LOCW] & quiet;
  wire bw_ev = bw_pulse & quiet;
  wire wake_ev = lw_ev | bw_ev;

  // ==========================================================
  // sleep hold timer
  // counts only while go-to-sleep stands and no wakeup is pending
  wire hold_run = (mode_reg == M_GTS) & (sel_mode == M_GTS) &
                  !wake_flag_reg & !wake_ev;
  wire hold_done = (hold_reg == CNT_W'(HOLD_C));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_reg <= '0;
    end else if (!hold_run) begin
      hold_reg <= '0;
    end else if (!hold_done) begin
      hold_reg <= hold_reg + 1'b1;
    end
  end

  // ==========================================================
  // mode state machine
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      M_SLEEP: begin
        if (stb_rise && pins_s.logic_supply) begin
          mode_next = sel_mode;
        end else if (wake_ev) begin
          mode_next = M_STANDBY;  // wakeup turns the regulator on
        end
      end
      M_GTS: begin
        // hold_run drops on a wakeup, so a late wake still beats sleep
        if (uv || (hold_done && hold_run)) begin
          mode_next = M_SLEEP;
        end else begin
          mode_next = sel_mode;
        end
      end
      M_NORMAL, M_LISTEN, M_STANDBY: begin
        mode_next = uv ? M_SLEEP : sel_mode;
      end
      default: begin
        mode_next = M_STANDBY;
      end
    endcase
  end
  wire enter_norm = (mode_next == M_NORMAL) & (mode_reg != M_NORMAL);
  wire leave_norm = (mode_next != M_NORMAL) & (mode_reg == M_NORMAL);
  wire enter_lst = (mode_next == M_LISTEN) & (mode_reg != M_LISTEN);
  wire enter_slp = (mode_next == M_SLEEP) & (mode_reg != M_SLEEP);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= M_STANDBY;
      stb_prev_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      stb_prev_reg <= pins_s.standby_select_n;
    end
  end

  // ==========================================================
  // flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_flag_reg <= 1'b1;  // set with the power-on flag
      power_on_flag_reg <= 1'b1;
      src_local_reg <= 1'b1;
      from_norm_reg <= 1'b0;
    end else begin
      if (wake_ev) begin
        wake_flag_reg <= 1'b1;
      end else if (enter_norm || uv) begin
        wake_flag_reg <= 1'b0;
      end
      if (enter_norm) begin
        power_on_flag_reg <= 1'b0;
      end
      if (lw_ev) begin
        src_local_reg <= 1'b1;
      end else if (bw_ev || leave_norm) begin
        src_local_reg <= 1'b0;  // cleared to remote; reset loads local
      end
      if (enter_lst) begin
        from_norm_reg <= (mode_reg == M_NORMAL);
      end
    end
  end

  // ==========================================================
  // txd activity qualifying the bus failure flag
  wire dom_ok = (dom_reg >= CNT_W'(TXDOM_CYC));
  wire tx_edge = pins_s.txd & !txd_prev_reg & dom_ok;  // dominant end
  wire bf_valid = (edge_reg == TX_EDGES);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dom_reg <= '0;
      txd_prev_reg <= 1'b1;
      edge_reg <= '0;
    end else begin
      txd_prev_reg <= pins_s.txd;
      if (pins_s.txd) begin
        dom_reg <= '0;
      end else if (!dom_ok) begin
        dom_reg <= dom_reg + 1'b1;
      end
      // count restarts on every entry into normal mode
      if (mode_reg != M_NORMAL) begin
        edge_reg <= '0;
      end else if (tx_edge && !bf_valid) begin
        edge_reg <= edge_reg + 1'b1;
      end
    end
  end

  // ==========================================================
  // fault and rxd pin selection
  always_comb begin
    case (mode_reg)
      M_NORMAL: begin
        if (bf_valid) begin
          fault_n_next = !pins_s.bus_flt;
        end else begin
          fault_n_next = !src_local_reg;
        end
      end
      M_LISTEN: begin
        if (!supplies_ok) begin
          fault_n_next = 1'b1;
        end else if (from_norm_reg) begin
          fault_n_next = !pins_s.local_flt;
        end else begin
          fault_n_next = !power_on_flag_reg;
        end
      end
      default: begin
        fault_n_next = !(wake_flag_reg & pins_s.logic_supply);
      end
    endcase
    if (quiet) begin
      rxd_next = !(wake_flag_reg & pins_s.logic_supply);
    end else begin
      rxd_next = !pins_s.bus_dom;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_n_reg <= 1'b1;
      rxd_reg <= 1'b1;
      inh_reg <= 1'b1;
    end else begin
      fault_n_reg <= fault_n_next;
      rxd_reg <= rxd_next;
      inh_reg <= (mode_reg != M_SLEEP);
    end
  end
  assign fault_flag_out_n = fault_n_reg;
  assign rxd_out = rxd_reg;
  // open drain to battery: drives high whenever enabled
  assign regulator_control_out = inh_reg;
  assign regulator_control_oe = inh_reg;

  // ==========================================================
  // wishbone slave, one wait state, unmapped reads give zero
  wire req = wb_cyc_i & wb_stb_i;
  wire wr = req & wb_we_i & ack_reg & wb_sel_i[0];  // write at ack edge
  wire hit_ctrl = (wb_adr_i == ADR_CTRL);
  wire hit_stat = (wb_adr_i == ADR_STAT);
  wire hit_ist = (wb_adr_i == ADR_IST);
  wire hit_imsk = (wb_adr_i == ADR_IMSK);
  wire [IRQ_W-1:0] ev_vec = {tx_edge & (edge_reg == 3'h3) &
                             (mode_reg == M_NORMAL), enter_slp, wake_ev};
  wire [31:0] stat_w = {20'h0, mode_reg, edge_reg, wake_flag_reg,
                        power_on_flag_reg, src_local_reg, from_norm_reg,
                        wake_bias_high, hold_done};
  wire [31:0] rdata = hit_ctrl ? {30'h0, ctrl_reg} :
                      hit_stat ? stat_w :
                      hit_ist ? {29'h0, ist_reg} :
                      hit_imsk ? {29'h0, imsk_reg} : 32'h0;
  // ack drops the cycle after it rose, so requests never merge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else begin
      ack_reg <= req & !ack_reg;
      dat_reg <= rdata;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ==========================================================
  // control and interrupt registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RST;
      imsk_reg <= IMSK_RST;
      ist_reg <= '0;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_reg <= wb_dat_i[1:0];
      end
      if (wr && hit_imsk) begin
        imsk_reg <= wb_dat_i[IRQ_W-1:0];
      end
      // new events win over a write-one clear in the same cycle
      if (wr && hit_ist) begin
        ist_reg <= (ist_reg & ~wb_dat_i[IRQ_W-1:0]) | ev_vec;
      end else begin
        ist_reg <= ist_reg | ev_vec;
      end
    end
  end
  assign irq_o = |(ist_reg & imsk_reg);

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_bus_flag;
    (mode_reg == M_NORMAL && bf_valid) |=>
      (fault_flag_out_n == !$past(pins_s.bus_flt));
  endproperty
  a_bus_flag: assert property (p_bus_flag)
    else $error("bus failure flag not shown");
  property p_src_flag;
    (mode_reg == M_NORMAL && edge_reg < 3'h4) |=>
      (fault_flag_out_n == !$past(src_local_reg));
  endproperty
  a_src_flag: assert property (p_src_flag)
    else $error("wake source flag not shown");
  property p_power_on_flag;
    (mode_reg == M_LISTEN && !from_norm_reg && supplies_ok) |=>
      (fault_flag_out_n == !$past(power_on_flag_reg));
  endproperty
  a_power_on_flag: assert property (p_power_on_flag)
    else $error("power-on flag not shown");
  property p_lfail;
    (mode_reg == M_LISTEN && from_norm_reg && supplies_ok) |=>
      (fault_flag_out_n == !$past(pins_s.local_flt));
  endproperty
  a_lfail: assert property (p_lfail)
    else $error("local failure flag not shown");
  property p_sleep;
    (mode_reg != M_SLEEP) ##1 (mode_reg == M_SLEEP) |->
      $past(uv) || ($past(hold_reg) == CNT_W'(HOLD_C));
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep entered without cause");
  property p_inh;
    ##1 1'b1 |-> (regulator_control_oe == ($past(mode_reg) != M_SLEEP));
  endproperty
  a_inh: assert property (p_inh)
    else $error("regulator output wrong for mode");
  property p_wake;
    (wake_ev && !uv) |=> wake_flag_reg ##1
      (!pins_s.logic_supply || (mode_reg == M_NORMAL) ||
       (mode_reg == M_LISTEN) || !rxd_out);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wakeup not flagged on rxd");
  property p_gts_wake;
    (mode_reg == M_GTS && wake_ev && !uv) |=>
      (mode_reg != M_SLEEP) ##1 regulator_control_oe;
  endproperty
  a_gts_wake: assert property (p_gts_wake)
    else $error("sleep taken over a wakeup");
  property p_edges;
    (mode_reg != M_NORMAL) |=> (edge_reg == 3'h0);
  endproperty
  a_edges: assert property (p_edges)
    else $error("edge count kept outside normal");

  c_bus_wake: cover property (bw_ev);
  c_local_wake: cover property (lw_ev);
  c_sleep: cover property (enter_slp && !uv);
  c_bf_valid: cover property (mode_reg == M_NORMAL && bf_valid);
endmodule : ctwf_top

// *** core/ctwf_pkg.sv ***
// shared constants, types and carriers of the wake and flag logic
package ctwf_pkg;
  // ==========================================================
  // timing, all at a 100 ns clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_TXDOM_NS = 4000;    // least dominant period on txd
  localparam int TXDOM_CYC = (T_TXDOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_BWPH_NS = 5000;     // least bus wake phase
  localparam int BWPH_CYC = (T_BWPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_BWWIN_NS = 500000;  // longest bus wake pattern
  localparam int BWWIN_CYC = T_BWWIN_NS / CLK_PERIOD_NS;
  localparam int T_HOLD_NS = 50000;    // sleep command hold time
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_WAKE_NS = 50000;    // wake pin filter time
  localparam int WAKE_CYC = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;           // width of every filter counter
  localparam logic [2:0] TX_EDGES = 3'h4;
  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_IST = 8'h08;
  localparam logic [7:0] ADR_IMSK = 8'h0C;
  localparam logic [1:0] CTRL_RST = 2'h3;  // both wake sources on
  localparam int CTRL_BUSW = 0;
  localparam int CTRL_LOCW = 1;
  localparam int IRQ_W = 3;
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_SLEEP = 1;
  localparam int IRQ_BFVAL = 2;
  localparam logic [IRQ_W-1:0] IMSK_RST = 3'h0;
  // ==========================================================
  // modes and states, gray along the usual path
  typedef enum logic [2:0] {
    M_NORMAL = 3'h0, M_LISTEN = 3'h1, M_STANDBY = 3'h3,
    M_GTS = 3'h2, M_SLEEP = 3'h6
  } ctwf_mode_t;
  typedef enum logic [1:0] {
    BW_IDLE = 2'h0, BW_DOM1 = 2'h1, BW_REC = 2'h3, BW_DOM2 = 2'h2
  } ctwf_bw_state_t;
  // ==========================================================
  // pin carrier: everything arriving from outside the clock
  typedef struct packed {
    logic standby_select_n;  // low selects standby or go-to-sleep
    logic enable_select;
    logic txd;               // low is dominant
    logic bus_dom;           // receiver sees dominant bus
    logic wake;              // local wake pin level
    logic logic_supply;      // logic supply present
    logic xcvr_supply;       // transceiver supply present
    logic bus_flt;           // bus failure detector
    logic local_flt;         // local failure detector
  } ctwf_pins_t;
  localparam ctwf_pins_t PINS_RST = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1,
                                      1'b1, 1'b1, 1'b0, 1'b0};
endpackage : ctwf_pkg

// *** core/ctwf_wake_filter.sv ***
// wake pin persistence filter with bias tracking
`timescale 1ns/1ps
module ctwf_wake_filter #(
  parameter int CYC = ctwf_pkg::WAKE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic level,
  output logic bias_high,
  output logic event_pulse
);
  import ctwf_pkg::*;
  // ==========================================================
  // counter of cycles spent away from the bias
  logic [CNT_W-1:0] cnt_reg;
  logic bias_reg;
  logic ev_reg;
  wire away = (level != bias_reg);
  wire done = (cnt_reg == CNT_W'(CYC));  // held longer than the filter
  // either edge counts; a glitch shorter than the filter restarts it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
      bias_reg <= 1'b1;  // pulled up until the pin says otherwise
      ev_reg <= 1'b0;
    end else if (!away) begin
      cnt_reg <= '0;
      ev_reg <= 1'b0;
    end else if (done) begin
      cnt_reg <= '0;
      bias_reg <= level;
      ev_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      ev_reg <= 1'b0;
    end
  end
  assign bias_high = bias_reg;
  assign event_pulse = ev_reg;
endmodule : ctwf_wake_filter

// *** core/ctwf_bus_wake.sv ***
// dominant-recessive-dominant bus wake pattern detector
`timescale 1ns/1ps
module ctwf_bus_wake #(
  parameter int PH_CYC = ctwf_pkg::BWPH_CYC,
  parameter int WIN_CYC = ctwf_pkg::BWWIN_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic bus_dom,
  output logic wake_pulse
);
  import ctwf_pkg::*;
  // ==========================================================
  // state and counters
  ctwf_bw_state_t st_reg, st_next;
  logic [CNT_W-1:0] ph_reg, ph_next;    // length of current phase
  logic [CNT_W-1:0] win_reg, win_next;  // age of the whole pattern
  logic pulse_reg, pulse_next;
  wire ph_done = (ph_reg >= CNT_W'(PH_CYC));
  wire win_over = (win_reg >= CNT_W'(WIN_CYC));
  // ==========================================================
  // next state; counters saturate so long idle never wraps
  always_comb begin
    st_next = st_reg;
    ph_next = ph_done ? ph_reg : ph_reg + 1'b1;
    win_next = win_over ? win_reg : win_reg + 1'b1;
    pulse_next = 1'b0;
    case (st_reg)
      BW_IDLE: begin
        if (bus_dom) begin
          st_next = BW_DOM1;
          ph_next = CNT_W'(1);
          win_next = CNT_W'(1);
        end
      end
      BW_DOM1: begin
        if (!bus_dom) begin
          st_next = ph_done ? BW_REC : BW_IDLE;
          ph_next = CNT_W'(1);
        end
      end
      BW_REC: begin
        if (bus_dom) begin
          // a short gap restarts the pattern at this dominant
          st_next = ph_done ? BW_DOM2 : BW_DOM1;
          ph_next = CNT_W'(1);
          if (!ph_done) begin
            win_next = CNT_W'(1);
          end
        end
      end
      BW_DOM2: begin
        if (!bus_dom) begin
          st_next = BW_IDLE;
        end else if (ph_done) begin
          st_next = BW_IDLE;
          pulse_next = 1'b1;
        end
      end
      default: begin
        st_next = BW_IDLE;
      end
    endcase
    // a pattern older than the window is dropped whole
    if (!enable || (win_over && st_reg != BW_IDLE)) begin
      st_next = BW_IDLE;
      pulse_next = 1'b0;
    end
  end
  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= BW_IDLE;
      ph_reg <= '0;
      win_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ph_reg <= ph_next;
      win_reg <= win_next;
      pulse_reg <= pulse_next;
    end
  end
  assign wake_pulse = pulse_reg;
endmodule : ctwf_bus_wake

// *** testbench/ctwf_bus_node.sv ***
// can bus node model sending one wake frame
`timescale 1ns/1ps
module ctwf_bus_node #(
  parameter int PH = 55
) (
  input wire logic clk,
  input wire logic go,
  output logic bus_dom
);
  int n; // cycles into the pattern, 0 when idle
  initial n = 0;
  // ==========================================================
  // pattern
  // dominant, recessive, dominant, then recessive idle
  always @(posedge clk) begin
    if (go || n != 0) n <= (n == 3 * PH) ? 0 : n + 1;
  end
  assign bus_dom = (n != 0) && ((n - 1) / PH != 1);
endmodule : ctwf_bus_node

// *** testbench/test_ctwf_top.sv ***
// self-checking bench of the wake and flag logic
`timescale 1ns/1ps
module test_ctwf_top;
  import ctwf_pkg::*;
  // ==========================================================
  // stimulus and wiring
  logic clk, resetn, cyc, stb, we, ack, go, bd;
  logic [7:0] adr;
  logic [31:0] dat, rdat;
  logic [3:0] sel;
  ctwf_pins_t p, pins; // p: bench pins, bus line comes from node
  logic flt_n, rxd, reg_o, reg_oe, bias, irq;
  logic [31:0] q[$]; // expected read data, oldest first
  int fail_count, cmp_count, d;
  assign pins = ctwf_pins_t'({p[8:6], bd, p[4:0]});
  ctwf_top #(.WIN_CYC(300), .HOLD_C(20), .WAKE_C(10)) dut (
    .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pins_i(pins),
    .fault_flag_out_n(flt_n), .rxd_out(rxd),
    .regulator_control_out(reg_o), .regulator_control_oe(reg_oe),
    .wake_bias_high(bias), .irq_o(irq));
  ctwf_bus_node node (.clk(clk), .go(go), .bus_dom(bd));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================================
  // tasks
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task w(input int c);
    repeat (c) @(posedge clk);
  endtask : w
  // one classic cycle; waits for ack, then releases
  task wb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= v;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (ack !== 1'b1) fail_count++; // a missing answer is a mismatch
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd
  task txpulse(input int c);
    p.txd <= 1'b0;
    w(c);
    p.txd <= 1'b1;
    w(10);
  endtask : txpulse
  // read answers are matched against the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) chk("rdata", q.pop_front(), rdat);
  end
  // hang guard, far beyond the fewer than a thousand cycles needed
  initial begin
    #3000000;
    fail_count++;
    print_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    {resetn, cyc, stb, we, go, adr, dat, sel} = '0;
    p = PINS_RST;
    fail_count = 0;
    cmp_count = 0;
    void'($urandom(32'hF144));
    w(12);
    resetn <= 1'b1;
    rd(ADR_CTRL, 32'h3);
    rd(ADR_IMSK, 32'h0);
    rd(8'h10, 32'h0);
    chk("oe", 1'b1, reg_oe);
    chk("out", 1'b1, reg_o);
    chk("fault", 1'b0, flt_n);
    p.standby_select_n <= 1'b1;
    w(8);
    chk("fault", 1'b0, flt_n);
    p.enable_select <= 1'b1;
    w(8);
    txpulse(30); // too short to count
    for (int i = 0; i < 4; i++) begin
      chk("fault", 1'b0, flt_n);
      d = 42 + $urandom % 20;
      txpulse(d);
    end
    chk("fault", 1'b1, flt_n);
    rd(ADR_IST, 32'h4);
    p.bus_flt <= 1'b1;
    w(8);
    chk("fault", 1'b0, flt_n);
    p.local_flt <= 1'b1;
    p.enable_select <= 1'b0;
    w(8);
    chk("fault", 1'b0, flt_n);
    chk("oe", 1'b1, reg_oe);
    wb(1'b1, ADR_IST, 32'h7);
    wb(1'b1, ADR_IMSK, 32'h2);
    p.standby_select_n <= 1'b0;
    p.enable_select <= 1'b1;
    w(12);
    chk("oe", 1'b1, reg_oe);
    w(20);
    chk("oe", 1'b0, reg_oe);
    chk("out", 1'b0, reg_o);
    chk("irq", 1'b1, irq);
    rd(ADR_IST, 32'h2);
    wb(1'b1, ADR_IST, 32'h2);
    w(1);
    chk("irq", 1'b0, irq);
    go <= 1'b1;
    w(1);
    go <= 1'b0;
    w(200);
    chk("oe", 1'b1, reg_oe);
    chk("rxd", 1'b0, rxd);
    chk("fault", 1'b0, flt_n);
    chk("irq", 1'b0, irq); // masked
    rd(ADR_IST, 32'h1);
    wb(1'b1, ADR_IST, 32'h1);
    p.wake <= 1'b0;
    w(5);
    p.wake <= 1'b1;
    w(20);
    chk("bias", 1'b1, bias);
    rd(ADR_IST, 32'h0);
    for (int i = 0; i < 2; i++) begin
      p.wake <= i[0];
      w(20);
      chk("bias", i, bias);
      rd(ADR_IST, 32'h1);
      wb(1'b1, ADR_IST, 32'h1);
    end
    // local wake disabled: bias still tracks, no event is kept
    wb(1'b1, ADR_CTRL, 32'h1);
    rd(ADR_CTRL, 32'h1);
    p.wake <= 1'b0;
    w(20);
    chk("bias", 1'b0, bias);
    rd(ADR_IST, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h3);
    p.logic_supply <= 1'b0;
    w(8);
    chk("oe", 1'b0, reg_oe);
    p.logic_supply <= 1'b1;
    p.enable_select <= 1'b0;
    w(8);
    p.standby_select_n <= 1'b1;
    w(8);
    chk("oe", 1'b1, reg_oe);
    chk("out", 1'b1, reg_o);
    print_verdict();
  end
endmodule : test_ctwf_top
